// >>> hw/pmf_pkg.sv
package pmf_pkg;

    // Register map of the mode block.
    localparam logic [7:0] PWR_CTRL_ADDR  = 8'h1b;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h10;
    localparam int         INV_BIT        = 6;
    localparam int         DLY_LSB        = 4;
    localparam int         DLY_MSB        = 5;

    // Clock rates, and the slow tick derived from the reference clock.
    localparam int REF_CLK_HZ  = 20_000_000;
    localparam int SLOW_CLK_HZ = 32_768;
    localparam int TICK_DIV    = REF_CLK_HZ / SLOW_CLK_HZ;

    // Times in microseconds, converted to whole slow-clock periods, rounded up.
    localparam longint DBNC_SHORT_US  = 31_250;
    localparam longint DBNC_MID_US    = 125_000;
    localparam longint DBNC_LONG_US   = 750_000;
    localparam longint LONG_PRESS_US  = 4_000_000;
    localparam int DBNC_SHORT_TICKS = int'((DBNC_SHORT_US * SLOW_CLK_HZ + 999_999) / 1_000_000);
    localparam int DBNC_MID_TICKS   = int'((DBNC_MID_US * SLOW_CLK_HZ + 999_999) / 1_000_000);
    localparam int DBNC_LONG_TICKS  = int'((DBNC_LONG_US * SLOW_CLK_HZ + 999_999) / 1_000_000);
    localparam int LONG_PRESS_TICKS = int'((LONG_PRESS_US * SLOW_CLK_HZ + 999_999) / 1_000_000);

    // Slow-clock stages that qualify the low-power request.
    localparam int REQ_SYNC_TICKS = 3;

    // Counter width for the debounce and run-length slow-clock counts.
    localparam int CNT_W = 18;

    // Power modes, one-hot.
    typedef enum logic [4:0] {
        ST_BACKUP  = 5'b00001,
        ST_OFF     = 5'b00010,
        ST_ON      = 5'b00100,
        ST_SLEEP   = 5'b01000,
        ST_STANDBY = 5'b10000
    } pmf_state_t;

endpackage : pmf_pkg

// >>> hw/pmf_power_mode_fsm.sv
`timescale 1ns/1ps
`default_nettype none

module pmf_power_mode_fsm #(
    parameter int NUM_REG          = 4,
    parameter int TICK_DIV         = pmf_pkg::TICK_DIV,
    parameter int DBNC_SHORT_TICKS = pmf_pkg::DBNC_SHORT_TICKS,
    parameter int DBNC_MID_TICKS   = pmf_pkg::DBNC_MID_TICKS,
    parameter int DBNC_LONG_TICKS  = pmf_pkg::DBNC_LONG_TICKS,
    parameter int LONG_PRESS_TICKS = pmf_pkg::LONG_PRESS_TICKS
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_in,
    input  wire logic               power_key_in,
    input  wire logic               lowpower_request_in,
    input  wire logic               vin_above_rise_in,
    input  wire logic               vin_below_fall_in,
    input  wire logic               thermal_shutdown_in,
    input  wire logic               key_style_select_in,
    input  wire logic               long_press_off_enable_in,
    input  wire logic [1:0]         key_debounce_select_in,
    input  wire logic [NUM_REG-1:0] regulator_sleep_keep_in,
    input  wire logic               irq_request_in,
    input  wire logic               reg_write_in,
    input  wire logic               reg_read_in,
    input  wire logic [7:0]         reg_addr_in,
    input  wire logic [7:0]         reg_wdata_in,
    input  wire logic               key_event_clear_in,
    output logic [4:0]              mode_out,
    output logic                    host_reset_out_n,
    output logic                    irq_out_n,
    output logic                    key_event_flag_out,
    output logic                    key_level_sense_out,
    output logic [NUM_REG-1:0]      regulator_enable_out,
    output logic                    sleep_setpoint_select_out,
    output logic                    standby_setting_select_out,
    output logic                    startup_sequence_out,
    output logic                    standby_mirror_load_out,
    output logic [7:0]              reg_rdata_out,
    output logic                    reg_ack_out,
    output logic                    reg_nack_out
);

    localparam int CW = pmf_pkg::CNT_W;

    // Refuse settings the counters cannot hold.
    initial begin
        if (TICK_DIV < 2 || TICK_DIV > 1023 || NUM_REG < 1 ||
            LONG_PRESS_TICKS >= (1 << CW) || DBNC_LONG_TICKS >= (1 << CW) ||
            DBNC_SHORT_TICKS < 1 || DBNC_MID_TICKS < 1 || LONG_PRESS_TICKS < 1) begin
            $error("pmf_power_mode_fsm: unsupported parameter values");
        end
    end

    pmf_pkg::pmf_state_t state_reg;
    pmf_pkg::pmf_state_t state_next;
    logic [4:0]          sync1_reg;
    logic [4:0]          sync2_reg;
    logic [9:0]          tick_cnt_reg;
    logic                tick_reg;
    logic [7:0]          pwr_ctrl_reg;
    logic                vin_ok_reg;
    logic                key_s;
    logic                therm_s;
    logic                kdb_reg;
    logic                kdb_init_reg;
    logic [CW-1:0]       dbnc_cnt_reg;
    logic [CW-1:0]       run_cnt_reg;
    logic                key_last_reg;
    logic                pb_armed_reg;
    logic [2:0]          req_sh_reg;
    logic                std_q_reg;
    logic [1:0]          dly_cnt_reg;
    logic                first_up_reg;
    logic                kdb_event;
    logic [CW-1:0]       dbnc_thr;
    logic [CW-1:0]       on_thr;
    logic                turn_on;
    logic                long_press;
    logic                key_off_req;
    logic                any_keep;
    logic                active_next;

    // Two-stage synchronisers for the key and low-power request pins and every comparator input.
    // They keep sampling through reset, so the key level is real when reset ends.
    // A reset value here would differ from a key idling high and fake an edge.
    always_ff @(posedge ref_clk_in) begin
        sync1_reg <= {thermal_shutdown_in, vin_below_fall_in, vin_above_rise_in,
                      lowpower_request_in, power_key_in};
        sync2_reg <= sync1_reg;
    end

    assign key_s   = sync2_reg[0];
    assign therm_s = sync2_reg[4];

    // slow tick
    // Deriving the tick from the reference clock keeps one clock domain at a small rate error.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tick_cnt_reg <= 10'h000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == 10'(TICK_DIV - 1)) begin
            tick_cnt_reg <= 10'h000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 10'h001;
            tick_reg     <= 1'b0;
        end
    end

    // power-up gate
    // Valid only above the rising threshold, invalid again only below the falling one.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            vin_ok_reg <= 1'b0;
        end else if (sync2_reg[3]) begin
            vin_ok_reg <= 1'b0;
        end else if (sync2_reg[2]) begin
            vin_ok_reg <= 1'b1;
        end
    end

    always_comb begin
        unique case (key_debounce_select_in)
            2'b00: on_thr = '0;
            2'b01: on_thr = CW'(DBNC_SHORT_TICKS);
            2'b10: on_thr = CW'(DBNC_MID_TICKS);
            2'b11: on_thr = CW'(DBNC_LONG_TICKS);
        endcase
        if (key_s) begin
            dbnc_thr = CW'(DBNC_SHORT_TICKS);
        end else if (key_debounce_select_in[1]) begin
            dbnc_thr = on_thr;
        end else begin
            dbnc_thr = CW'(DBNC_SHORT_TICKS);
        end
    end

    // key debounce
    // The debounced level is loaded once after reset so that reset raises no edge.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            kdb_reg      <= 1'b0;
            kdb_init_reg <= 1'b0;
            dbnc_cnt_reg <= '0;
        end else if (!kdb_init_reg) begin
            kdb_reg      <= key_s;
            kdb_init_reg <= 1'b1;
        end else if (key_s == kdb_reg) begin
            dbnc_cnt_reg <= '0;
        end else if (tick_reg) begin
            if (dbnc_cnt_reg + CW'(1) >= dbnc_thr) begin
                kdb_reg      <= key_s;
                dbnc_cnt_reg <= '0;
            end else begin
                dbnc_cnt_reg <= dbnc_cnt_reg + CW'(1);
            end
        end
    end

    assign kdb_event = kdb_init_reg && (key_s != kdb_reg) && tick_reg &&
                       (dbnc_cnt_reg + CW'(1) >= dbnc_thr);

    // Run length of the present key level, saturating at the long-press time.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            run_cnt_reg  <= '0;
            key_last_reg <= 1'b0;
        end else begin
            key_last_reg <= key_s;
            if (key_s != key_last_reg) begin
                run_cnt_reg <= '0;
            end else if (tick_reg && run_cnt_reg < CW'(LONG_PRESS_TICKS)) begin
                run_cnt_reg <= run_cnt_reg + CW'(1);
            end
        end
    end

    // pushbutton arming
    // A press is used once; the key must be seen released before it can turn on again.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pb_armed_reg <= 1'b0;
        end else if (key_s) begin
            pb_armed_reg <= 1'b1;
        end else if (turn_on && key_style_select_in) begin
            pb_armed_reg <= 1'b0;
        end
    end

    // key before input
    // A level key already high simply waits in backup until the input becomes valid.
    assign turn_on = vin_ok_reg && !therm_s && (run_cnt_reg >= on_thr) &&
                     (key_style_select_in ? (!key_s && pb_armed_reg) : key_s);

    assign long_press = key_style_select_in && long_press_off_enable_in && !key_s &&
                        (run_cnt_reg >= CW'(LONG_PRESS_TICKS));

    assign key_off_req = key_style_select_in ? long_press : !key_s;
    assign any_keep    = |regulator_sleep_keep_in;

    // request sync
    // Three slow-clock stages after the pin synchroniser qualify the request.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            req_sh_reg <= 3'h0;
        end else if (tick_reg) begin
            req_sh_reg <= {req_sh_reg[1:0], sync2_reg[1] ^ pwr_ctrl_reg[pmf_pkg::INV_BIT]};
        end
    end

    // entry delay
    // The delay holds off entry only; a dropped request is followed at the next tick.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            std_q_reg   <= 1'b0;
            dly_cnt_reg <= 2'h0;
        end else if (tick_reg) begin
            if (!req_sh_reg[2]) begin
                std_q_reg   <= 1'b0;
                dly_cnt_reg <= 2'h0;
            end else if (!std_q_reg) begin
                if (dly_cnt_reg == pwr_ctrl_reg[pmf_pkg::DLY_MSB:pmf_pkg::DLY_LSB]) begin
                    std_q_reg   <= 1'b1;
                    dly_cnt_reg <= 2'h0;
                end else begin
                    dly_cnt_reg <= dly_cnt_reg + 2'h1;
                end
            end
        end
    end

    // Next power mode.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pmf_pkg::ST_BACKUP: begin
                if (vin_ok_reg) begin
                    state_next = pmf_pkg::ST_OFF;
                end
            end
            pmf_pkg::ST_OFF: begin
                if (!vin_ok_reg) begin
                    state_next = pmf_pkg::ST_BACKUP;
                end else if (turn_on) begin
                    state_next = pmf_pkg::ST_ON;
                end
            end
            pmf_pkg::ST_ON, pmf_pkg::ST_STANDBY: begin
                if (!vin_ok_reg) begin
                    state_next = pmf_pkg::ST_BACKUP;
                end else if (therm_s) begin
                    state_next = pmf_pkg::ST_OFF;
                end else if (key_off_req) begin
                    state_next = any_keep ? pmf_pkg::ST_SLEEP : pmf_pkg::ST_OFF;
                end else if (state_reg == pmf_pkg::ST_ON && std_q_reg) begin
                    state_next = pmf_pkg::ST_STANDBY;
                end else if (state_reg == pmf_pkg::ST_STANDBY && !std_q_reg) begin
                    state_next = pmf_pkg::ST_ON;
                end
            end
            pmf_pkg::ST_SLEEP: begin
                if (!vin_ok_reg) begin
                    state_next = pmf_pkg::ST_BACKUP;
                end else if (therm_s || long_press) begin
                    state_next = pmf_pkg::ST_OFF;
                end else if (turn_on) begin
                    state_next = pmf_pkg::ST_ON;
                end
            end
            default: state_next = pmf_pkg::ST_BACKUP;
        endcase
    end

    // full reset
    // Reset is the backup-supply loss; the machine restarts as if only the cell remains.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= pmf_pkg::ST_BACKUP;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active_next = state_next == pmf_pkg::ST_ON || state_next == pmf_pkg::ST_SLEEP ||
                         state_next == pmf_pkg::ST_STANDBY;

    // sleep interrupts
    // Outputs are computed from the next mode so that they flip together with it.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            host_reset_out_n <= 1'b0;
            irq_out_n        <= 1'b1;
        end else begin
            host_reset_out_n <= state_next == pmf_pkg::ST_ON ||
                                state_next == pmf_pkg::ST_STANDBY;
            irq_out_n        <= !(irq_request_in && active_next);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            regulator_enable_out       <= '0;
            sleep_setpoint_select_out  <= 1'b0;
            standby_setting_select_out <= 1'b0;
            startup_sequence_out       <= 1'b0;
        end else begin
            if (state_next == pmf_pkg::ST_ON || state_next == pmf_pkg::ST_STANDBY) begin
                regulator_enable_out <= '1;
            end else if (state_next == pmf_pkg::ST_SLEEP) begin
                regulator_enable_out <= regulator_sleep_keep_in;
            end else begin
                regulator_enable_out <= '0;
            end
            sleep_setpoint_select_out  <= state_next == pmf_pkg::ST_SLEEP;
            standby_setting_select_out <= state_next == pmf_pkg::ST_STANDBY;
            startup_sequence_out       <= state_reg == pmf_pkg::ST_OFF &&
                                          state_next == pmf_pkg::ST_ON;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            first_up_reg            <= 1'b1;
            standby_mirror_load_out <= 1'b0;
        end else begin
            standby_mirror_load_out <= first_up_reg && state_next == pmf_pkg::ST_ON;
            if (state_next == pmf_pkg::ST_ON) begin
                first_up_reg <= 1'b0;
            end
        end
    end

    // flags on turn-on
    // Setting wins over clearing so no edge is lost in the clearing cycle.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            key_event_flag_out <= 1'b0;
        // Leaving standby is not a turn-on, so only off and sleep exits raise the flag.
        end else if (kdb_event || (turn_on && state_next == pmf_pkg::ST_ON &&
                                   (state_reg == pmf_pkg::ST_OFF ||
                                    state_reg == pmf_pkg::ST_SLEEP))) begin
            key_event_flag_out <= 1'b1;
        end else if (key_event_clear_in || state_reg == pmf_pkg::ST_OFF) begin
            key_event_flag_out <= 1'b0;
        end
    end

    // raw key sense
    // The sense bit tracks the pin even in reset, so it is right from the first edge.
    always_ff @(posedge ref_clk_in) begin
        key_level_sense_out <= key_s;
    end

    // access refusal
    // Other addresses belong to other register blocks and get no answer here, except in backup, where every access is refused.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pwr_ctrl_reg  <= pmf_pkg::PWR_CTRL_RESET;
            reg_rdata_out <= 8'h00;
            reg_ack_out   <= 1'b0;
            reg_nack_out  <= 1'b0;
        end else begin
            reg_ack_out  <= 1'b0;
            reg_nack_out <= 1'b0;
            if (reg_write_in || reg_read_in) begin
                if (state_reg == pmf_pkg::ST_BACKUP) begin
                    reg_nack_out <= 1'b1;
                end else if (reg_addr_in == pmf_pkg::PWR_CTRL_ADDR) begin
                    reg_ack_out <= 1'b1;
                    if (reg_write_in) begin
                        pwr_ctrl_reg <= reg_wdata_in;
                    end else begin
                        reg_rdata_out <= pwr_ctrl_reg;
                    end
                end
            end
        end
    end

    assign mode_out = state_reg;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    chk_no_early_on: assert property (
        state_reg == pmf_pkg::ST_OFF && !vin_ok_reg |=> state_reg == pmf_pkg::ST_BACKUP)
        else $error("power-up without valid input");
    chk_backup_refused: assert property (
        reg_write_in && state_reg == pmf_pkg::ST_BACKUP |=> reg_nack_out && $stable(pwr_ctrl_reg))
        else $error("register access taken in backup mode");
    chk_on_reset_high: assert property (
        state_reg == pmf_pkg::ST_ON |-> host_reset_out_n)
        else $error("host reset asserted in on mode");
    chk_off_reset_low: assert property (
        state_reg == pmf_pkg::ST_OFF || state_reg == pmf_pkg::ST_BACKUP |-> !host_reset_out_n)
        else $error("host reset released in off or backup");
    chk_standby_entry: assert property (
        state_reg == pmf_pkg::ST_ON && std_q_reg && vin_ok_reg && !therm_s && !key_off_req
        |=> state_reg == pmf_pkg::ST_STANDBY)
        else $error("standby not entered");
    chk_entry_delay: assert property (
        $rose(std_q_reg) |-> $past(dly_cnt_reg) == pwr_ctrl_reg[5:4] && $past(tick_reg))
        else $error("standby entry delay wrong");
    chk_backup_hold: assert property (
        state_reg == pmf_pkg::ST_BACKUP && !vin_ok_reg |=> state_reg == pmf_pkg::ST_BACKUP)
        else $error("left backup without valid input");
    chk_key_flag_set: assert property (
        kdb_event |=> key_event_flag_out)
        else $error("key event flag not set");
    chk_sense_follow: assert property (
        key_level_sense_out == $past(key_s))
        else $error("key sense lags");
    chk_uv_backup: assert property (
        state_reg != pmf_pkg::ST_BACKUP && !vin_ok_reg ##1 1 |-> state_reg == pmf_pkg::ST_BACKUP ||
        $past(state_reg) == pmf_pkg::ST_BACKUP)
        else $error("undervoltage did not reach backup");

    cov_standby: cover property (state_reg == pmf_pkg::ST_ON ##1 state_reg == pmf_pkg::ST_STANDBY);
    cov_sleep: cover property (state_reg == pmf_pkg::ST_ON ##1 state_reg == pmf_pkg::ST_SLEEP);
    cov_wake: cover property (state_reg == pmf_pkg::ST_SLEEP ##1 state_reg == pmf_pkg::ST_ON);
    cov_long_off: cover property (long_press && state_reg == pmf_pkg::ST_ON);

endmodule : pmf_power_mode_fsm

`default_nettype wire

// >>> tb/pmf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host and pushbutton: both pins are plain levels that the bench commands.
module pmf_host_model (
    input  wire logic ref_clk_in,
    input  wire logic key_cmd_in,
    input  wire logic req_cmd_in,
    output var logic  power_key_out,
    output var logic  lowpower_request_out
);
    // Pins start released low and move on the falling edge, away from sampling.
    initial begin
        power_key_out = 1'b0;
        lowpower_request_out = 1'b0;
    end
    always @(negedge ref_clk_in) begin
        power_key_out <= key_cmd_in;
        lowpower_request_out <= req_cmd_in;
    end
endmodule : pmf_host_model
`default_nettype wire

// >>> tb/pmf_power_mode_fsm_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pmf_power_mode_fsm_bench;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic ack;
                           logic [7:0] rd;} pmf_row_t;
    logic       ref_clk_in, rst_in, key_cmd, req_cmd, key, req, vin_ok, vin_low, hot, irq_req;
    logic       wr, rd, clr, ack, nack, rst_n, irq_n, flag, sense, sel_sl, sel_sb;
    logic       style, lp_en, start, mirror;
    logic [1:0] dbsel;
    logic [7:0] addr, wdata, rdata;
    logic [4:0] mode;
    logic [3:0] keep, en;
    int         n_mismatch = 0, n_tests = 0;
    // Register traffic in off mode: reset value, unmapped place, spare bits kept.
    pmf_row_t   rows [5] = '{'{1'b0, 8'h1b, 8'h00, 1'b1, 8'h10}, '{1'b1, 8'h1b, 8'h8f, 1'b1, 8'h00},
        '{1'b1, 8'h1c, 8'h00, 1'b0, 8'h00}, '{1'b0, 8'h1b, 8'h00, 1'b1, 8'h8f},
        '{1'b1, 8'h1b, 8'h10, 1'b1, 8'h00}};

    pmf_host_model pmf_host_model_i (.ref_clk_in(ref_clk_in), .key_cmd_in(key_cmd),
        .req_cmd_in(req_cmd), .power_key_out(key), .lowpower_request_out(req));
    // Short counts keep the run brief; every mode wait below is bounded, not exact.
    pmf_power_mode_fsm #(.TICK_DIV(4), .DBNC_SHORT_TICKS(2), .DBNC_MID_TICKS(3),
        .DBNC_LONG_TICKS(4), .LONG_PRESS_TICKS(6)) pmf_power_mode_fsm_i (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .power_key_in(key), .lowpower_request_in(req),
        .vin_above_rise_in(vin_ok), .vin_below_fall_in(vin_low), .thermal_shutdown_in(hot),
        .key_style_select_in(style), .long_press_off_enable_in(lp_en),
        .key_debounce_select_in(dbsel), .regulator_sleep_keep_in(keep), .irq_request_in(irq_req),
        .reg_write_in(wr), .reg_read_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .key_event_clear_in(clr), .mode_out(mode), .host_reset_out_n(rst_n), .irq_out_n(irq_n),
        .key_event_flag_out(flag), .key_level_sense_out(sense), .regulator_enable_out(en),
        .sleep_setpoint_select_out(sel_sl), .standby_setting_select_out(sel_sb),
        .startup_sequence_out(start), .standby_mirror_load_out(mirror), .reg_rdata_out(rdata),
        .reg_ack_out(ack), .reg_nack_out(nack));

    // Free-running reference clock.
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One strobe cycle; the answer stands in the cycle after the taking edge.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        {wr, rd, addr, wdata} = {w, !w, a, d};
        @(negedge ref_clk_in);
        {wr, rd} = 2'h0;
    endtask : access

    task automatic wait_mode(input pmf_pkg::pmf_state_t m);
        int i;
        for (i = 0; i < 400 && mode !== m; i++) @(negedge ref_clk_in);
        check(8'(mode), 8'(m));
    endtask : wait_mode

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Main sequence: reset, register rows, then each mode path by hand.
    initial begin
        {rst_in, key_cmd, req_cmd, vin_ok, vin_low, hot, irq_req, wr, rd, clr} = 10'h200;
        {addr, wdata, keep, style, lp_en, dbsel} = 24'h0;
        repeat (16) @(negedge ref_clk_in);
        rst_in = 1'b0;
        check(8'(mode), 8'h01);
        check(8'({rst_n, irq_n, flag, en}), 8'h20);
        access(1'b0, 8'h1b, 8'h00);
        check(8'({ack, nack}), 8'h01);
        vin_ok = 1'b1;
        wait_mode(pmf_pkg::ST_OFF);
        check(8'(rst_n), 8'h00);
        foreach (rows[i]) begin
            access(rows[i].wr, rows[i].addr, rows[i].data);
            check(8'({nack, ack}), 8'(rows[i].ack));
            if (!rows[i].wr) check(rdata, rows[i].rd);
        end
        check(8'(mode), 8'h02);
        key_cmd = 1'b1;
        wait_mode(pmf_pkg::ST_ON);
        check(8'({rst_n, flag, sense, en}), 8'h7f);
        clr = 1'b1;
        @(negedge ref_clk_in) clr = 1'b0;
        check(8'(flag), 8'h00);
        irq_req = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        check(8'(irq_n), 8'h00);
        req_cmd = 1'b1;
        repeat (10) @(negedge ref_clk_in);
        check(8'(mode), 8'h04);
        wait_mode(pmf_pkg::ST_STANDBY);
        check(8'({rst_n, sel_sb}), 8'h03);
        req_cmd = 1'b0;
        wait_mode(pmf_pkg::ST_ON);
        access(1'b1, 8'h1b, 8'h50);
        wait_mode(pmf_pkg::ST_STANDBY);
        req_cmd = 1'b1;
        wait_mode(pmf_pkg::ST_ON);
        access(1'b1, 8'h1b, 8'h10);
        wait_mode(pmf_pkg::ST_STANDBY);
        req_cmd = 1'b0;
        wait_mode(pmf_pkg::ST_ON);
        hot = 1'b1;
        wait_mode(pmf_pkg::ST_OFF);
        check(8'({rst_n, irq_n}), 8'h01);
        hot = 1'b0;
        wait_mode(pmf_pkg::ST_ON);
        {keep, key_cmd} = 5'h02;
        wait_mode(pmf_pkg::ST_SLEEP);
        check(8'({sel_sl, en}), 8'h11);
        key_cmd = 1'b1;
        wait_mode(pmf_pkg::ST_ON);
        check(8'({start, en}), 8'h0f);
        {vin_ok, vin_low} = 2'h1;
        wait_mode(pmf_pkg::ST_BACKUP);
        check(8'(rst_n), 8'h00);
        // Pushbutton, longest debounce, long-press off: the press turns on late, the hold off.
        {vin_ok, vin_low, keep, style, lp_en, dbsel} = 10'h20f;
        wait_mode(pmf_pkg::ST_OFF);
        key_cmd = 1'b0;
        repeat (8) @(negedge ref_clk_in);
        check(8'(mode), 8'h02);
        wait_mode(pmf_pkg::ST_ON);
        check(8'({start, mirror, flag}), 8'h05);
        wait_mode(pmf_pkg::ST_OFF);
        // The same press must not turn the device on a second time.
        repeat (20) @(negedge ref_clk_in);
        check(8'(mode), 8'h02);
        // Loss of the backup supply mid-run: register and first-power-up state return.
        access(1'b1, 8'h1b, 8'h30);
        key_cmd = 1'b1;
        rst_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        rst_in = 1'b0;
        check(8'({mode, rst_n, flag}), 8'h04);
        wait_mode(pmf_pkg::ST_OFF);
        access(1'b0, 8'h1b, 8'h00);
        check(rdata, 8'h10);
        key_cmd = 1'b0;
        wait_mode(pmf_pkg::ST_ON);
        check(8'({start, mirror, flag}), 8'h07);
        complete_run();
    end

    // A hang is cut short well past the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_mismatch++;
        complete_run();
    end
endmodule : pmf_power_mode_fsm_bench
`default_nettype wire
